// ---- design/ulpi_startup_ctrl.v ----
// Start-up, reset, chip select, stop protection and supply control of the transceiver
`timescale 1ns/100ps
`include "ulpi_startup_defines.vh"
//
// Contract
// R1 - Assert DIR after power-on, release on PLL lock
// R2 - DIR high: NXT low, data carries status
// R3 - Link drives bus low while DIR low
// R4 - Link ignores status until its first reset
// R5 - Link writes reset bit before packets
// R6 - Reset bit holds DIR, then self-clears
// R7 - One status byte after every reset
// R8 - Clock output starts when DIR falls
// R9 - Link waits, sees DIR low three cycles
// R10 - After power-on: DIR high, others low
// R11 - DIR stays low until link reset command
// R12 - Stop high unexpectedly enables data pull-downs
// R13 - Protection disable bit turns protection off
// R14 - Reset pin low: DIR high, all reset; PLL power and clock output enable are kept
// R15 - Link drives data and stop low during reset
// R16 - DIR falls four cycles after pin release; DIR here falls only after the release count, turnaround and status byte
// R17 - Chip select off: tri-state, idle, ignore commands
// R18 - Chip select off: stop exits serial only
// R19 - PLL unpowered at power-up with chip select off
// R20 - Drive bits choose pump or external supply
// R21 - Fault monitored only with both bits set
// R22 - Fault maps to supply valid, sends status
// R23 - Link idles bus at all zero
// R24 - Any status field change sends status byte
// R25 - Link stays off bus while DIR high

module ulpi_startup_ctrl #(
   parameter RESET_CYCLES   = `RESET_CYCLES,
   parameter RELEASE_CYCLES = `RELEASE_CYCLES,
   parameter REF_TIMEOUT    = `REF_TIMEOUT
) (
   input  wire       clock,
   input  wire       rst,
   input  wire       resetPinN,
   input  wire       chipSelectN,
   input  wire       stopIn,
   input  wire       pllLock,
   input  wire       refClockIn,
   input  wire       faultIn,
   input  wire [7:0] dataIn,
   input  wire       resetBitWrite,
   input  wire       stopProtectionDisable,
   input  wire       internalPumpEnable,
   input  wire       externalSupplyEnable,
   input  wire       externalIndicatorSelect,
   input  wire       indicatorPassthrough,
   input  wire       lastModeSerial,
   input  wire [1:0] lineState,
   input  wire [1:0] vbusState,
   input  wire [1:0] rxEvent,
   input  wire       idPin,
   input  wire       altInt,
   output reg        dirOut,
   output reg        dirOe,
   output reg        nxtOut,
   output reg        nxtOe,
   output reg  [7:0] dataOut,
   output reg        dataOe,
   output reg        dataPullDown,
   output reg        stopPullUp,
   output reg        pllPowerOn,
   output reg        clockOutEnable,
   output reg        chargePumpOn,
   output reg        supplySwitchOutLow,
   output reg        supplySwitchOutLowOe,
   output reg        resetBitStatus,
   output reg        stopExitRequest,
   output reg        busReady
);

   ////////////////////////////////////////////////////////////////////////////
   // States, one-hot
   localparam [7:0] ST_PWRUP    = 8'h01;
   localparam [7:0] ST_LINKWAIT = 8'h02;
   localparam [7:0] ST_RSTHOLD  = 8'h04;
   localparam [7:0] ST_PINHOLD  = 8'h08;
   localparam [7:0] ST_PINREL   = 8'h10;
   localparam [7:0] ST_TURN     = 8'h20;
   localparam [7:0] ST_SEND     = 8'h40;
   localparam [7:0] ST_READY    = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; reset and select pins enter inverted so that cleared stages
   // read as no pin reset and chip deselected, at the cost of two undriven cycles
   wire [13:0] syncVec;
   wire        resetPinSync;
   wire        csSyncN;
   wire        stopSync;
   wire        pllLockSync;
   wire        refClockSync;
   wire        faultSync;
   wire [7:0]  dataSync;

   sync_bits #(
      .WIDTH   (14)
   ) pinSync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn ({~resetPinN, ~chipSelectN, stopIn, pllLock, refClockIn, faultIn, dataIn}),
      .syncOut (syncVec)
   );

   assign resetPinSync = ~syncVec[13];
   assign csSyncN      = ~syncVec[12];
   assign stopSync     = syncVec[11];
   assign pllLockSync  = syncVec[10];
   assign refClockSync = syncVec[9];
   assign faultSync    = syncVec[8];
   assign dataSync     = syncVec[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [7:0]  state_reg;
   reg [7:0]  state_next;
   reg [15:0] count_reg;
   reg [15:0] count_next;
   reg [7:0]  lastStatus_reg;
   reg        resetBit_reg;
   reg        normalOp_reg;
   reg        refPrev_reg;
   reg [7:0]  refIdle_reg;
   reg        refPresent_reg;

   // Reset pin low synchronously resets sequencer, reset bit and last status; PLL power is kept
   wire pinReset = ~resetPinSync;
   wire csActive = ~csSyncN;

   ////////////////////////////////////////////////////////////////////////////
   // Status byte assembly
   // R21 monitor gate
   wire faultMonitor = externalIndicatorSelect & indicatorPassthrough;
   reg  [7:0] statusByte;

   // R22 fault replaces supply valid bit
   always @* begin
      statusByte = `STATUS_RESET;
      statusByte[`LINE_STATE_LSB+1:`LINE_STATE_LSB] = lineState;
      statusByte[`VBUS_STATE_LSB+1:`VBUS_STATE_LSB] = vbusState;
      if (faultMonitor) begin
         statusByte[`SUPPLY_VALID_BIT] = ~faultSync;
      end
      statusByte[`RX_EVENT_LSB+1:`RX_EVENT_LSB] = rxEvent;
      statusByte[`ID_BIT] = idPin;
      statusByte[`ALT_INT_BIT] = altInt;
   end

   // R24 change in any field
   wire statusChanged = (statusByte != lastStatus_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Reference clock presence, timed out when edges stop
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         refPrev_reg    <= 1'b0;
         refIdle_reg    <= 8'h00;
         refPresent_reg <= 1'b0;
      end else begin
         refPrev_reg <= refClockSync;
         if (refPrev_reg != refClockSync) begin
            refIdle_reg    <= 8'h00;
            refPresent_reg <= 1'b1;
         end else if (refIdle_reg == REF_TIMEOUT[7:0]) begin
            refPresent_reg <= 1'b0;
         end else begin
            refIdle_reg <= refIdle_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer
   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         ST_PWRUP: begin
            // R1 hold DIR until PLL is stable
            if (pllPowerOn && pllLockSync) begin
               state_next = ST_LINKWAIT;
            end
         end
         ST_LINKWAIT: begin
            // R11 wait for the link reset command
            if (resetBit_reg) begin
               state_next = ST_RSTHOLD;
               count_next = 16'h0000;
            end
         end
         ST_RSTHOLD: begin
            // R6 internal reset in progress
            if (count_reg == RESET_CYCLES[15:0] - 16'h0001) begin
               state_next = ST_SEND;
            end else begin
               count_next = count_reg + 16'h0001;
            end
         end
         ST_PINHOLD: begin
            // R16 start counting only with chip select active
            if (csActive) begin
               state_next = ST_PINREL;
               count_next = 16'h0001;
            end
         end
         ST_PINREL: begin
            if (count_reg == {12'h000, RELEASE_CYCLES[3:0]} - 16'h0001) begin
               state_next = ST_TURN;
            end else begin
               count_next = count_reg + 16'h0001;
            end
         end
         ST_TURN: begin
            state_next = ST_SEND;
         end
         ST_SEND: begin
            state_next = ST_READY;
         end
         ST_READY: begin
            if (resetBit_reg) begin
               state_next = ST_RSTHOLD;
               count_next = 16'h0000;
            end else if (statusChanged && dataSync == `DATA_IDLE) begin
               // Only start a status byte while the link idles the bus
               state_next = ST_TURN;
            end
         end
         default: begin
            state_next = ST_PWRUP;
         end
      endcase
      // R17 turnaround, send and ready states forced to ready while deselected
      if (!csActive && (state_reg == ST_TURN || state_reg == ST_SEND || state_reg == ST_READY)) begin
         state_next = ST_READY;
      end
      // R14 pin reset overrides everything
      if (pinReset) begin
         state_next = ST_PINHOLD;
         count_next = 16'h0000;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_PWRUP;
         count_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset bit, PLL power, last sent status
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         resetBit_reg   <= 1'b0;
         normalOp_reg   <= 1'b0;
         pllPowerOn     <= 1'b0;
         lastStatus_reg <= `STATUS_RESET;
      end else if (pinReset) begin
         resetBit_reg   <= 1'b0;
         lastStatus_reg <= `STATUS_RESET;
         pllPowerOn     <= pllPowerOn | csActive;
      end else begin
         // R17 writes ignored while deselected; R6 set wins over self-clear
         if (resetBitWrite && csActive) begin
            resetBit_reg <= 1'b1;
         end else if (state_reg == ST_RSTHOLD && state_next == ST_SEND) begin
            resetBit_reg <= 1'b0;
         end
         // R19 PLL powered once selected, then kept on
         if (csActive || normalOp_reg) begin
            pllPowerOn <= 1'b1;
         end
         if (state_reg != ST_PWRUP) begin
            normalOp_reg <= 1'b1;
         end
         // R7 remember what the link last saw
         if (state_reg == ST_SEND) begin
            lastStatus_reg <= statusByte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interface pin drive, all registered
   wire dirNext = (state_next == ST_PWRUP) || (state_next == ST_RSTHOLD) || (state_next == ST_PINHOLD) ||
                  (state_next == ST_PINREL) || (state_next == ST_TURN) || (state_next == ST_SEND);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         // R10 DIR high, others low after power-on
         dirOut  <= 1'b1;
         dirOe   <= 1'b1;
         nxtOut  <= 1'b0;
         nxtOe   <= 1'b1;
         dataOut <= `DATA_IDLE;
         dataOe  <= 1'b1;
      end else begin
         // R1 DIR follows the sequencer
         dirOut <= dirNext;
         // R2 NXT low, no data path here
         nxtOut <= 1'b0;
         // R17 tri-state while deselected
         dirOe <= csActive;
         nxtOe <= csActive;
         // R2 status byte on data while DIR high, idle zero in power-up and pin hold; turnaround cycle leaves bus free
         dataOe <= csActive && dirNext && (state_next != ST_TURN);
         if (state_next == ST_PWRUP || state_next == ST_PINHOLD) begin
            dataOut <= `DATA_IDLE;
         end else begin
            dataOut <= statusByte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop pin protection and exit request
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         stopPullUp      <= 1'b1;
         dataPullDown    <= 1'b0;
         stopExitRequest <= 1'b0;
      end else begin
         // R12 weak pull-up on stop by default
         stopPullUp <= 1'b1;
         // R12 stop high while link idle; R13 disable; R17 off when deselected
         dataPullDown <= stopSync && (dataSync == `DATA_IDLE) && !dirOut &&
                         !stopProtectionDisable && csActive;
         // R18 stop exits serial mode only
         stopExitRequest <= !csActive && lastModeSerial && stopSync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock output and supply control
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         clockOutEnable       <= 1'b0;
         chargePumpOn         <= 1'b0;
         supplySwitchOutLow   <= 1'b0;
         supplySwitchOutLowOe <= 1'b0;
         resetBitStatus       <= 1'b0;
         busReady             <= 1'b0;
      end else begin
         // R8 clock out once DIR first falls with a reference present
         if (!refPresent_reg || !pllPowerOn) begin
            clockOutEnable <= 1'b0;
         end else if (!dirNext && state_reg != ST_PWRUP) begin
            clockOutEnable <= 1'b1;
         end
         // R20 external bit wins; open drain pulls low when enabled
         chargePumpOn         <= internalPumpEnable && !externalSupplyEnable && !pinReset;
         supplySwitchOutLow   <= 1'b0;
         supplySwitchOutLowOe <= externalSupplyEnable && !pinReset;
         resetBitStatus       <= resetBit_reg;
         busReady             <= (state_reg == ST_READY);
      end
   end

endmodule

// ---- design/ulpi_startup_defines.vh ----
// Constants for the start-up, reset and supply control of the transceiver
`ifndef ULPI_STARTUP_DEFINES_VH
`define ULPI_STARTUP_DEFINES_VH

// Cycle counts at the 100 MHz core clock
`define RESET_CYCLES       16'h0020
`define RELEASE_CYCLES     4'h4
`define REF_TIMEOUT        8'h10

// Status byte field positions
`define LINE_STATE_LSB     0
`define VBUS_STATE_LSB     2
`define SUPPLY_VALID_BIT   3
`define RX_EVENT_LSB       4
`define ID_BIT             6
`define ALT_INT_BIT        7

// Reset values
`define STATUS_RESET       8'h00
`define DATA_IDLE          8'h00

`endif

// ---- design/sync_bits.v ----
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps

module sync_bits #(
   parameter WIDTH = 1
) (
   input  wire             clock,
   input  wire             rst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   // First stage is read only by the second
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;

endmodule

// ---- testbench/ulpi_startup_properties.sv ----
// Checker with concurrent properties for the start-up block
`timescale 1ns/100ps

module ulpi_startup_checker (
   input logic clock,
   input logic rst,
   input logic resetPinN,
   input logic chipSelectN,
   input logic resetBitWrite,
   input logic stopProtectionDisable,
   input logic internalPumpEnable,
   input logic externalSupplyEnable,
   input logic dirOut,
   input logic dirOe,
   input logic nxtOut,
   input logic nxtOe,
   input logic dataOe,
   input logic dataPullDown,
   input logic chargePumpOn,
   input logic supplySwitchOutLowOe,
   input logic resetBitStatus
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////
   AST_NXT_LOW: assert property (dirOut |-> !nxtOut)
      else $error("nxt high while dir high");
   AST_PUMP: assert property (!$past(rst) && $past(resetPinN, 3) |->
      chargePumpOn == $past(internalPumpEnable && !externalSupplyEnable))
      else $error("charge pump wrong");
   AST_EXT: assert property (!$past(rst) && $past(resetPinN, 3) |->
      supplySwitchOutLowOe == $past(externalSupplyEnable))
      else $error("external supply switch wrong");
   AST_CS_OFF: assert property (chipSelectN[*4] |-> !dirOe && !nxtOe && !dataOe && !dataPullDown)
      else $error("pins driven while deselected");
   AST_PROT_OFF: assert property (stopProtectionDisable[*3] |-> !dataPullDown)
      else $error("pull-downs while protection off");
   AST_PIN_HOLD: assert property ((!resetPinN)[*5] |-> dirOut)
      else $error("dir low during pin reset");
   AST_PIN_REL: assert property ($rose(resetPinN) && !chipSelectN |-> dirOut[*5] ##[1:8] !dirOut)
      else $error("dir release after pin reset off");
   AST_BIT_SET: assert property ((!chipSelectN)[*4] ##0 resetBitWrite |-> ##2 resetBitStatus)
      else $error("reset bit not set");
   AST_BIT_DIR: assert property ($rose(resetBitStatus) |-> ##[0:1] dirOut)
      else $error("dir not raised by reset bit");
   AST_BIT_CLR: assert property ($rose(resetBitStatus) |-> ##[1:40] !resetBitStatus)
      else $error("reset bit never cleared");
   AST_SEND: assert property ($fell(resetBitStatus) && resetPinN |-> $past(dirOut && dataOe) && !dirOut)
      else $error("no status byte after reset");

   // Main scenarios seen at least once
   cover property ($fell(dirOut));
   cover property ($rose(dataPullDown));
   cover property ($fell(resetBitStatus));
endmodule

bind ulpi_startup_ctrl ulpi_startup_checker i_chk (.clock(clock), .rst(rst), .resetPinN(resetPinN),
   .chipSelectN(chipSelectN), .resetBitWrite(resetBitWrite), .stopProtectionDisable(stopProtectionDisable),
   .internalPumpEnable(internalPumpEnable), .externalSupplyEnable(externalSupplyEnable), .dirOut(dirOut),
   .dirOe(dirOe), .nxtOut(nxtOut), .nxtOe(nxtOe), .dataOe(dataOe), .dataPullDown(dataPullDown),
   .chargePumpOn(chargePumpOn), .supplySwitchOutLowOe(supplySwitchOutLowOe), .resetBitStatus(resetBitStatus));

// ---- testbench/link_model.sv ----
// Link controller model on the far side of the bus
`timescale 1ns/100ps

module link_model (
   input  logic       clock,
   input  logic       rst,
   input  logic       dirOut,
   input  logic       dirOe,
   input  logic [7:0] dataOut,
   input  logic       dataOe,
   input  logic       stopReq,
   input  logic       resetReq,
   input  int         slowCycles,
   output logic [7:0] dataIn,
   output logic       stopIn,
   output logic       resetBitWrite,
   output logic       gotValid,
   output logic [7:0] gotByte
);
   logic       dirSeen, prevDir, ready;
   logic [7:0] lastWire;
   int         lowCnt;

   assign dirSeen = dirOe & dirOut;
   // idle zero, released wire never repeats its last value
   assign dataIn = dataOe ? dataOut : (!dirSeen && !prevDir) ? 8'h00 : ~lastWire;
   assign stopIn = stopReq;

   // wait three plus slowCycles low cycles, write reset, trust status only after
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         prevDir       <= 1'b1;
         ready         <= 1'b0;
         lowCnt        <= 0;
         resetBitWrite <= 1'b0;
         gotValid      <= 1'b0;
         lastWire      <= 8'h00;
         gotByte       <= 8'h00;
      end else begin
         prevDir       <= dirSeen;
         lastWire      <= dataIn;
         lowCnt        <= (dirOe && !dirOut) ? lowCnt + 1 : 0;
         resetBitWrite <= 1'b0;
         if (dataOe && dirSeen)
            gotByte <= dataOut;
         gotValid <= ready && prevDir && !dirSeen;
         if (lowCnt >= 2 + slowCycles && !resetBitWrite && (!ready || resetReq)) begin
            resetBitWrite <= 1'b1;
            ready         <= 1'b1;
         end
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the start-up block
`timescale 1ns/100ps

module tb_top;
   logic       clock = 1'b0, rst = 1'b1, resetPinN = 1'b1, chipSelectN = 1'b0, pllLock = 1'b0;
   logic       refClockIn = 1'b0, faultIn = 1'b0, stopProtectionDisable = 1'b0, internalPumpEnable = 1'b0;
   logic       externalSupplyEnable = 1'b0, externalIndicatorSelect = 1'b0, indicatorPassthrough = 1'b0;
   logic       lastModeSerial = 1'b0, idPin = 1'b0, altInt = 1'b0, stopReq = 1'b0, resetReq = 1'b0;
   logic [1:0] lineState = 2'h0, vbusState = 2'h0, rxEvent = 2'h0;
   logic       dirOut, dirOe, nxtOut, nxtOe, dataOe, dataPullDown, stopPullUp, pllPowerOn, clockOutEnable;
   logic       chargePumpOn, supplySwitchOutLow, supplySwitchOutLowOe, resetBitStatus, stopExitRequest;
   logic       busReady, resetBitWrite, stopIn, gotValid;
   logic [7:0] dataIn, dataOut, gotByte, r;
   logic [7:0] gotQ[$];
   int         n_errors = 0, tests_run = 0, slowCycles = 20, i, n;

   ////////////////////////////////////////////////////////////////
   // Core clock and free-running reference
   always #5 clock = ~clock;
   always #40 refClockIn = ~refClockIn;
   // Collect status bytes seen by the link
   always @(posedge clock) if (gotValid) gotQ.push_back(gotByte);

   ulpi_startup_ctrl #(.RESET_CYCLES(4)) i_dut (.clock(clock), .rst(rst), .resetPinN(resetPinN),
      .chipSelectN(chipSelectN), .stopIn(stopIn), .pllLock(pllLock), .refClockIn(refClockIn), .faultIn(faultIn),
      .dataIn(dataIn), .resetBitWrite(resetBitWrite), .stopProtectionDisable(stopProtectionDisable),
      .internalPumpEnable(internalPumpEnable), .externalSupplyEnable(externalSupplyEnable),
      .externalIndicatorSelect(externalIndicatorSelect), .indicatorPassthrough(indicatorPassthrough),
      .lastModeSerial(lastModeSerial), .lineState(lineState), .vbusState(vbusState), .rxEvent(rxEvent),
      .idPin(idPin), .altInt(altInt), .dirOut(dirOut), .dirOe(dirOe), .nxtOut(nxtOut), .nxtOe(nxtOe),
      .dataOut(dataOut), .dataOe(dataOe), .dataPullDown(dataPullDown), .stopPullUp(stopPullUp),
      .pllPowerOn(pllPowerOn), .clockOutEnable(clockOutEnable), .chargePumpOn(chargePumpOn),
      .supplySwitchOutLow(supplySwitchOutLow), .supplySwitchOutLowOe(supplySwitchOutLowOe),
      .resetBitStatus(resetBitStatus), .stopExitRequest(stopExitRequest), .busReady(busReady));

   link_model i_link (.clock(clock), .rst(rst), .dirOut(dirOut), .dirOe(dirOe), .dataOut(dataOut),
      .dataOe(dataOe), .stopReq(stopReq), .resetReq(resetReq), .slowCycles(slowCycles), .dataIn(dataIn),
      .stopIn(stopIn), .resetBitWrite(resetBitWrite), .gotValid(gotValid), .gotByte(gotByte));

   // Expected status byte, fault replaces supply-valid when both bits set
   function automatic logic [7:0] expStatus();
      logic [1:0] v;
      v = vbusState;
      if (externalIndicatorSelect && indicatorPassthrough)
         v[1] = ~faultIn;
      return {altInt, idPin, rxEvent, v, lineState};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bounded wait for the next status byte; a timeout forces a mismatch
   task automatic waitByte(input logic [7:0] exp);
      for (n = 0; n < 60 && gotQ.size() == 0; n++)
         @(negedge clock);
      chk(gotQ.size() ? gotQ.pop_front() : ~exp, exp);
   endtask

   task automatic settle(input int c);
      repeat (c) @(negedge clock);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #200000;
      n_errors++;
      complete_run;
   end

   initial begin
      void'($urandom(32'h8cc0));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      settle(20);
      // bus held, clock off before lock
      chk({dirOut, nxtOut, clockOutEnable, dataOut}, 11'h400);
      @(posedge clock);
      pllLock <= 1'b1;
      for (n = 0; n < 50 && dirOut; n++) @(negedge clock);
      settle(10);
      // no release of the wait before the link reset
      chk({dirOut, clockOutEnable, busReady}, 3'b010);
      waitByte(expStatus());
      chk(resetBitStatus, 1'b0);
      slowCycles = 0;
      $display("done: power-up");
      // Status field changes, each must produce one byte
      for (i = 0; i < 6; i++) begin
         r = $urandom;
         if (r == {altInt, idPin, rxEvent, vbusState, lineState}) r = ~r;
         @(posedge clock);
         {altInt, idPin, rxEvent, vbusState, lineState} <= r;
         @(negedge clock);
         waitByte(expStatus());
      end
      $display("done: status");
      @(posedge clock);
      externalIndicatorSelect <= 1'b1;
      indicatorPassthrough <= 1'b1;
      settle(40);
      gotQ.delete();
      for (i = 0; i < 2; i++) begin
         @(posedge clock);
         faultIn <= ~faultIn;
         @(negedge clock);
         waitByte(expStatus());
      end
      @(posedge clock);
      indicatorPassthrough <= 1'b0;
      settle(40);
      gotQ.delete();
      @(posedge clock);
      faultIn <= 1'b1;
      settle(40);
      chk(gotQ.size(), 16'h0);
      $display("done: fault");
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         {externalSupplyEnable, internalPumpEnable} <= i[1:0];
         settle(3);
         chk({chargePumpOn, supplySwitchOutLowOe, supplySwitchOutLow}, {i == 1, i >= 2, 1'b0});
      end
      $display("done: supply");
      for (i = 0; i < 2; i++) begin
         @(posedge clock);
         stopProtectionDisable <= i[0];
         stopReq <= 1'b1;
         settle(5);
         chk({stopPullUp, dataPullDown}, {1'b1, i == 0});
         @(posedge clock);
         stopReq <= 1'b0;
         settle(5);
      end
      $display("done: protection");
      for (i = 0; i < 2; i++) begin
         @(posedge clock);
         chipSelectN <= 1'b1;
         lastModeSerial <= i[0];
         stopReq <= 1'b1;
         settle(5);
         chk({dirOe, nxtOe, dataOe, dataPullDown, stopExitRequest}, {4'h0, i == 1});
         @(posedge clock);
         chipSelectN <= 1'b0;
         stopReq <= 1'b0;
         settle(8);
      end
      $display("done: chip select");
      @(posedge clock);
      resetPinN <= 1'b0;
      settle(6);
      chk({dirOut, resetBitStatus}, 2'b10);
      @(posedge clock);
      resetPinN <= 1'b1;
      for (n = 0; n < 30 && dirOut; n++) @(negedge clock);
      chk(n >= 4 && n <= 10, 1'b1);
      waitByte(expStatus());
      $display("done: pin reset");
      @(posedge clock);
      resetReq <= 1'b1;
      for (n = 0; n < 20 && !resetBitStatus; n++) @(negedge clock);
      @(posedge clock);
      resetReq <= 1'b0;
      waitByte(expStatus());
      chk({resetBitStatus, busReady}, 2'b01);
      $display("done: software reset");
      @(posedge clock);
      rst <= 1'b1;
      chipSelectN <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      settle(10);
      chk(pllPowerOn, 1'b0);
      @(posedge clock);
      chipSelectN <= 1'b0;
      settle(5);
      chk(pllPowerOn, 1'b1);
      waitByte(expStatus());
      $display("done: deselected power-up");
      complete_run;
   end
endmodule
